/* File: verilog/lrba_pkg.sv */
// lrba_pkg: register map, field layout and shared types of the level-2 ram arbiter
// assumes a 32-bit apb slave whose byte addresses equal the printed offsets
`default_nettype none
package lrba_pkg;
  // ---------------------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [31:0] INTERNAL_DMA_CH1_SRC_ADDR = 32'h0182_0108; // channel 1 source
  localparam logic [31:0] INTERNAL_DMA_CH1_DST_ADDR = 32'h0182_010c; // channel 1 destination
  localparam logic [31:0] INTERNAL_DMA_CH1_CNT_ADDR = 32'h0182_0110; // count and priority
  localparam logic [31:0] CORE_ARB_ADDR = 32'h0184_1000; // core priority and wait
  localparam logic [31:0] MST_PRI1_ADDR = 32'h01c1_4114; // master priorities one
  localparam logic [31:0] MST_PRI2_ADDR = 32'h01c1_4118; // master priorities two
  localparam logic [31:0] ARB_STATUS_ADDR = 32'h0184_1004; // grant and counter status
  localparam logic [31:0] DMA_WAIT_ADDR = 32'h0184_1008; // dma wait threshold
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int PRI_W = 3; // priority level width, 0 is highest
  localparam int INTERNAL_DMA_PRI_SHIFT = 29; // priority field inside count register
  localparam int WAIT_SHIFT = 16; // wait threshold field in core register
  localparam int WAIT_W = 6; // wait threshold width
  localparam int MST_SHIFT = 0; // master 0 priority field inside master register one
  localparam int MST_SEL_SHIFT = 4; // master register two field for master id 1
  localparam logic [PRI_W-1:0] CMD_LEVEL = 3'h7; // internal command logic level
  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] CORE_ARB_RST = 32'h0010_0001; // core level 1, wait 16
  localparam logic [31:0] INTERNAL_DMA_CNT_RST = 32'h0000_0000; // channel 1 level 0
  localparam logic [31:0] MST_PRI_RST = 32'h0000_0044; // masters at level 4
  localparam logic [31:0] DMA_WAIT_RST = 32'h0000_0010; // dma wait 16
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic core; // processor core
    logic dma; // internal or slave-port dma
  } lrba_req_t;
  typedef enum logic [1:0] {
    LRBA_NONE,
    LRBA_CORE,
    LRBA_DMA
  } lrba_owner_t;
endpackage : lrba_pkg
`default_nettype wire

/* File: verilog/lrba_arbiter.sv */
// lrba_arbiter: bandwidth manager sharing level-2 ram slots between core and dma
// assumes same-clock request lines held until granted and an apb master on sys_clk
//
// Our own choice: the APB interface to the registers.
`default_nettype none
module lrba_arbiter (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic core_req,
  input wire logic internal_dma_req,
  input wire logic slave_dma_port_req,
  input wire logic slave_dma_port_master,
  output logic core_gnt,
  output logic dma_gnt,
  output logic internal_dma_sel
);
  // ---------------------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------------------
  logic rst_meta_r; // first release stage
  logic rst_n_r; // released reset used everywhere
  // two-stage release of the asynchronous reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [31:0] src_r; // channel 1 source
  logic [31:0] dst_r; // channel 1 destination
  logic [31:0] cnt_r; // channel 1 size and priority
  logic [31:0] core_arb_r; // core priority and wait
  logic [31:0] mst1_r; // master priority one
  logic [31:0] mst2_r; // master priority two
  logic [31:0] dma_wait_r; // dma wait threshold
  logic [lrba_pkg::WAIT_W-1:0] core_cnt_r; // core contention counter
  logic [lrba_pkg::WAIT_W-1:0] dma_cnt_r; // dma contention counter
  logic last_core_r; // last slot contested by a dma request went to core
  logic wr_en; // write strobe at access completion
  logic rd_en; // read strobe at access completion

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && penable && !pwrite && pready;

  // apb write path
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      src_r <= lrba_pkg::ZERO_RST;
      dst_r <= lrba_pkg::ZERO_RST;
      cnt_r <= lrba_pkg::INTERNAL_DMA_CNT_RST;
      core_arb_r <= lrba_pkg::CORE_ARB_RST;
      mst1_r <= lrba_pkg::MST_PRI_RST;
      mst2_r <= lrba_pkg::MST_PRI_RST;
      dma_wait_r <= lrba_pkg::DMA_WAIT_RST;
    end else if (wr_en) begin
      unique case (paddr)
        lrba_pkg::INTERNAL_DMA_CH1_SRC_ADDR: src_r <= pwdata;
        lrba_pkg::INTERNAL_DMA_CH1_DST_ADDR: dst_r <= pwdata;
        lrba_pkg::INTERNAL_DMA_CH1_CNT_ADDR: cnt_r <= pwdata;
        lrba_pkg::CORE_ARB_ADDR: core_arb_r <= pwdata;
        lrba_pkg::MST_PRI1_ADDR: mst1_r <= pwdata;
        lrba_pkg::MST_PRI2_ADDR: mst2_r <= pwdata;
        lrba_pkg::DMA_WAIT_ADDR: dma_wait_r <= pwdata;
        default: ; // unmapped writes are dropped and flagged
      endcase
    end
  end

  // decode for mapped addresses
  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a == lrba_pkg::INTERNAL_DMA_CH1_SRC_ADDR) || (a == lrba_pkg::INTERNAL_DMA_CH1_DST_ADDR)
             || (a == lrba_pkg::INTERNAL_DMA_CH1_CNT_ADDR) || (a == lrba_pkg::CORE_ARB_ADDR)
             || (a == lrba_pkg::MST_PRI1_ADDR) || (a == lrba_pkg::MST_PRI2_ADDR)
             || (a == lrba_pkg::ARB_STATUS_ADDR) || (a == lrba_pkg::DMA_WAIT_ADDR);
  endfunction : is_mapped

  // apb handshake: one wait state, answer in the second access cycle
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !is_mapped(paddr);
    end
  end

  // read data registered alongside pready
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      unique case (paddr)
        lrba_pkg::INTERNAL_DMA_CH1_SRC_ADDR: prdata <= src_r;
        lrba_pkg::INTERNAL_DMA_CH1_DST_ADDR: prdata <= dst_r;
        lrba_pkg::INTERNAL_DMA_CH1_CNT_ADDR: prdata <= cnt_r;
        lrba_pkg::CORE_ARB_ADDR: prdata <= core_arb_r;
        lrba_pkg::MST_PRI1_ADDR: prdata <= mst1_r;
        lrba_pkg::MST_PRI2_ADDR: prdata <= mst2_r;
        lrba_pkg::DMA_WAIT_ADDR: prdata <= dma_wait_r;
        // status word: core counter 17:12, dma counter 9:4, tie and grant flags 3:0
        lrba_pkg::ARB_STATUS_ADDR: prdata <= {14'h0000, core_cnt_r, 2'h0, dma_cnt_r,
                                             last_core_r, core_gnt, dma_gnt, internal_dma_sel};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // priority sources
  // ---------------------------------------------------------------------------
  logic [lrba_pkg::PRI_W-1:0] core_pri; // core level
  logic [lrba_pkg::PRI_W-1:0] internal_dma_pri; // channel 1 level
  logic [lrba_pkg::PRI_W-1:0] slave_dma_port_pri; // slave-port level of the active master
  logic [lrba_pkg::PRI_W-1:0] dma_pri; // merged dma level
  logic [lrba_pkg::WAIT_W-1:0] core_wait; // core wait threshold
  logic [lrba_pkg::WAIT_W-1:0] dma_wait; // dma wait threshold
  logic dma_any; // any non-core request
  logic dma_stall; // command logic holds the slave port

  assign core_pri = core_arb_r[lrba_pkg::PRI_W-1:0];
  assign internal_dma_pri = cnt_r[lrba_pkg::INTERNAL_DMA_PRI_SHIFT +: lrba_pkg::PRI_W];
  // master 0 priority from register one, master 1 from register two
  assign slave_dma_port_pri = slave_dma_port_master ? mst2_r[lrba_pkg::MST_SEL_SHIFT +: lrba_pkg::PRI_W]
                                : mst1_r[lrba_pkg::MST_SHIFT +: lrba_pkg::PRI_W];
  assign core_wait = core_arb_r[lrba_pkg::WAIT_SHIFT +: lrba_pkg::WAIT_W];
  assign dma_wait = dma_wait_r[lrba_pkg::WAIT_W-1:0];
  // internal_dma and slave port merge into one dma requester, better level wins
  // equal levels take internal_dma with no lost slot
  always_comb begin
    if (internal_dma_req && (!slave_dma_port_req || internal_dma_pri <= slave_dma_port_pri)) begin
      dma_pri = internal_dma_pri;
    end else begin
      dma_pri = slave_dma_port_pri;
    end
  end
  assign dma_any = internal_dma_req || slave_dma_port_req;
  // slave traffic stalls while core requests on the command level and internal_dma is idle
  assign dma_stall = slave_dma_port_req && !internal_dma_req && (core_pri == lrba_pkg::CMD_LEVEL) && core_req;

  // ---------------------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------------------
  logic dma_ok; // dma may compete this slot
  logic core_win; // core takes the slot
  logic dma_win; // dma takes the slot
  logic core_due; // core counter at threshold
  logic dma_due; // dma counter at threshold

  assign dma_ok = dma_any && !dma_stall;
  assign core_due = core_req && (core_cnt_r >= core_wait);
  assign dma_due = dma_ok && (dma_cnt_r >= dma_wait);

  // slot decision
  always_comb begin
    core_win = 1'b0;
    dma_win = 1'b0;
    if (dma_due && !core_due) begin
      dma_win = 1'b1; // starved dma forced in
    end else if (core_due && !dma_due) begin
      core_win = 1'b1;
    end else if (core_req && dma_ok) begin
      if (core_pri < dma_pri) begin
        core_win = 1'b1;
      end else if (dma_pri < core_pri) begin
        dma_win = 1'b1;
      end else begin
        core_win = !last_core_r; // alternate on ties
        dma_win = last_core_r;
      end
    end else begin
      core_win = core_req;
      dma_win = dma_ok;
    end
  end

  // tie alternation memory
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      last_core_r <= 1'b0;
    end else if (core_win && dma_any) begin
      last_core_r <= 1'b1;
    end else if (dma_win && core_req) begin
      last_core_r <= 1'b0;
    end
  end

  // contention counters, clear on grant, saturate at top
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      core_cnt_r <= '0;
      dma_cnt_r <= '0;
    end else begin
      if (core_win || !core_req) begin
        core_cnt_r <= '0;
      end else if (core_cnt_r != '1) begin
        core_cnt_r <= core_cnt_r + 1'b1;
      end
      if (dma_win || !dma_any) begin
        dma_cnt_r <= '0;
      end else if (dma_cnt_r != '1) begin
        dma_cnt_r <= dma_cnt_r + 1'b1;
      end
    end
  end

  // registered grants
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      core_gnt <= 1'b0;
      dma_gnt <= 1'b0;
      internal_dma_sel <= 1'b0;
    end else begin
      core_gnt <= core_win;
      dma_gnt <= dma_win;
      internal_dma_sel <= dma_win && internal_dma_req && (!slave_dma_port_req || internal_dma_pri <= slave_dma_port_pri);
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  AST_ONE_OWNER: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    !(core_gnt && dma_gnt)) else $error("both sides granted");
  AST_DMA_AS_ONE: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    (slave_dma_port_req && !core_req && !internal_dma_req) |=> dma_gnt) else $error("lone slave dma not granted");
  AST_COUNT_UP: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    (core_req && !core_win && core_cnt_r < core_wait) |=> core_cnt_r == $past(core_cnt_r) + 1'b1)
    else $error("core counter did not count");
  AST_STARVE: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    (dma_due && !core_due) |=> dma_gnt) else $error("due dma not granted");
  AST_TIE: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    (core_win && dma_ok && core_pri == dma_pri && !core_due && !dma_due) ##1
    (core_req && dma_ok && core_pri == dma_pri && !core_due && !dma_due) |=> dma_gnt)
    else $error("tie did not alternate");
  AST_CMD_STALL: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    dma_stall |=> !dma_gnt) else $error("slave dma passed command level");
  AST_HIGH_WINS: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    (core_req && dma_ok && core_pri < dma_pri && !dma_due) |=> core_gnt)
    else $error("higher core lost");
  AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
    dma_win |=> dma_cnt_r == '0) else $error("dma counter not cleared");
endmodule : lrba_arbiter
`default_nettype wire

/* File: verification/lrba_requester.sv */
// lrba_requester: behavioural requester standing for the core or a dma master
// assumes grants are one-cycle pulses on sys_clk and that one grant serves one slot
`default_nettype none
module lrba_requester (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [7:0] slots,
  input wire logic gnt,
  output logic req,
  output logic [7:0] left
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // slots still wanted
  // ---------------------------------------------------------------------------
  // reload on command, one slot fewer per grant
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) left <= 8'h00;
    else if (load) left <= slots;
    else if (gnt && left != 8'h00) left <= left - 8'h01;
  end
  // level held until granted; dropped with the last grant so no spare slot is taken
  assign req = (left > 8'h01) || (left == 8'h01 && !gnt);
endmodule : lrba_requester
`default_nettype wire

/* File: verification/lrba_arbiter_tb.sv */
// lrba_arbiter_tb: apb register checks and arbitration scenarios for the l2 ram arbiter
// assumes three lrba_requester models drive the request lines, apb master in this module
`default_nettype none
module lrba_arbiter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic core_req, internal_dma_req, slave_dma_port_req, slave_dma_port_master = 1'b0;
  logic core_gnt, dma_gnt, internal_dma_sel, load = 1'b0;
  logic [7:0] c_sl = 8'h0, i_sl = 8'h0, s_sl = 8'h0, c_left, i_left, s_left;
  logic [1:0] seq[$]; // grant owners: 1 core, 2 internal dma, 3 slave port
  int miscompares = 0, checks_done = 0, b, n, k;
  logic [31:0] rd;
  logic er;
  lrba_arbiter dut (.sys_clk(sys_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_req(core_req), .internal_dma_req(internal_dma_req), .slave_dma_port_req(slave_dma_port_req),
    .slave_dma_port_master(slave_dma_port_master), .core_gnt(core_gnt), .dma_gnt(dma_gnt), .internal_dma_sel(internal_dma_sel));
  lrba_requester core_m (.sys_clk(sys_clk), .resetn(resetn), .load(load), .slots(c_sl),
    .gnt(core_gnt), .req(core_req), .left(c_left));
  lrba_requester internal_dma_m (.sys_clk(sys_clk), .resetn(resetn), .load(load), .slots(i_sl),
    .gnt(dma_gnt & internal_dma_sel), .req(internal_dma_req), .left(i_left));
  lrba_requester slave_dma_port_m (.sys_clk(sys_clk), .resetn(resetn), .load(load), .slots(s_sl),
    .gnt(dma_gnt & !internal_dma_sel), .req(slave_dma_port_req), .left(s_left));
  // clock at 25 mhz
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // grant monitor: log the owner of every served slot
  always @(posedge sys_clk) begin
    if (core_gnt === 1'b1) seq.push_back(2'h1);
    if (dma_gnt === 1'b1) seq.push_back(internal_dma_sel === 1'b1 ? 2'h2 : 2'h3);
  end
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int w;
    w = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", w < 20, 1'b1);
  endtask : apb
  // load slot counts into the requesters and wait until all are served
  task automatic run(input logic [7:0] c, input logic [7:0] i, input logic [7:0] s);
    @(posedge sys_clk);
    b = seq.size();
    c_sl <= c;
    i_sl <= i;
    s_sl <= s;
    load <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((c_left | i_left | s_left) != 8'h0 && n < 300);
    repeat (3) @(posedge sys_clk);
    check("all slots served", n < 300, 1'b1);
  endtask : run
  // closing verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end
  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // reset values of the register table
    apb(1'b0, lrba_pkg::CORE_ARB_ADDR, 32'h0);
    check("core arb reset", rd, lrba_pkg::CORE_ARB_RST);
    apb(1'b0, lrba_pkg::INTERNAL_DMA_CH1_CNT_ADDR, 32'h0);
    check("count reset", rd, lrba_pkg::INTERNAL_DMA_CNT_RST);
    apb(1'b0, lrba_pkg::MST_PRI1_ADDR, 32'h0);
    check("master one reset", rd, lrba_pkg::MST_PRI_RST);
    apb(1'b0, lrba_pkg::MST_PRI2_ADDR, 32'h0);
    check("master two reset", rd, lrba_pkg::MST_PRI_RST);
    apb(1'b1, lrba_pkg::INTERNAL_DMA_CH1_SRC_ADDR, 32'h1234_5678);
    apb(1'b1, lrba_pkg::INTERNAL_DMA_CH1_DST_ADDR, 32'h9abc_def0);
    apb(1'b0, lrba_pkg::INTERNAL_DMA_CH1_SRC_ADDR, 32'h0);
    check("source rw", rd, 32'h1234_5678);
    apb(1'b0, lrba_pkg::INTERNAL_DMA_CH1_DST_ADDR, 32'h0);
    check("destination rw", rd, 32'h9abc_def0);
    apb(1'b0, 32'h0184_1ffc, 32'h0);
    check("unmapped read zero", rd, 32'h0000_0000);
    check("unmapped error", {31'h0000_0000, er}, 32'h0000_0001);
    $display("test registers done");
    // starved internal dma is forced in after its wait threshold
    apb(1'b1, lrba_pkg::INTERNAL_DMA_CH1_CNT_ADDR, 32'ha000_0000);
    apb(1'b1, lrba_pkg::DMA_WAIT_ADDR, 32'h0000_0004);
    run(8'd40, 8'd1, 8'd0);
    k = 99;
    for (int j = 39; j >= 0; j--) if (seq[b + j] == 2'h2) k = j;
    check("core wins first", seq[b], 2'h1);
    check("forced grant slot", k >= 4 && k <= 6, 1'b1);
    check("forced grant", k != 99, 1'b1);
    $display("test starvation done");
    // equal levels share slots evenly
    apb(1'b1, lrba_pkg::CORE_ARB_ADDR, 32'h003f_0002);
    apb(1'b1, lrba_pkg::INTERNAL_DMA_CH1_CNT_ADDR, 32'h4000_0000);
    apb(1'b1, lrba_pkg::DMA_WAIT_ADDR, 32'h0000_003f);
    run(8'd8, 8'd8, 8'd0);
    k = 0;
    for (int j = 0; j < 8; j++) k += (seq[b + j] == 2'h1);
    check("even share", k, 4);
    $display("test equal levels done");
    // slave port level follows the selected master register
    apb(1'b1, lrba_pkg::CORE_ARB_ADDR, 32'h003f_0004);
    apb(1'b1, lrba_pkg::MST_PRI1_ADDR, 32'h0000_0003);
    apb(1'b1, lrba_pkg::MST_PRI2_ADDR, 32'h0000_0060);
    for (int m = 0; m < 2; m++) begin
      slave_dma_port_master <= m[0];
      run(8'd2, 8'd0, 8'd2);
      check("master level winner", seq[b], m == 0 ? 2'h3 : 2'h1);
      check("slave counted as dma", seq.size() - b, 4);
    end
    $display("test master levels done");
    // core at the command level starves the slave port
    apb(1'b1, lrba_pkg::CORE_ARB_ADDR, 32'h003f_0007);
    apb(1'b1, lrba_pkg::MST_PRI1_ADDR, 32'h0000_0000);
    slave_dma_port_master <= 1'b0;
    run(8'd6, 8'd0, 8'd1);
    check("slave stalled", seq[b + 6], 2'h3);
    $display("test command level done");
    // equal internal and slave levels lose no slot: both at level 0 here
    apb(1'b1, lrba_pkg::INTERNAL_DMA_CH1_CNT_ADDR, 32'h0000_0000);
    run(8'd0, 8'd4, 8'd4);
    check("internal first", seq[b], 2'h2);
    check("no lost slot", n <= 10, 1'b1);
    $display("test equal dma done");
    end_sim();
  end
endmodule : lrba_arbiter_tb
`default_nettype wire
